// ### mms_top.sv
// module management: mdio slave, shadow memory, state sequence, alarm, led
// Function
// (R1) device is a clause 45 mdio slave; host drives the clock
// (R2) works with management clock up to 4 MHz
// (R3) module registers decoded only for device address 1
// (R4) five port address pins give the port address
// (R5) port address pin changes take effect without reset
// (R6) incomplete or corrupted frames cause no write, no partial state
// (R7) shadow memory dual ported: host and internal agents at once
// (R8) nonvolatile store copied in at init; save writes it back
// (R9) diagnostic value refreshed at most 1 ms apart
// (R10) in reset: data line released, reads all ones, writes ignored
// (R11) after reset short initialize state, then low power state
// (R12) internal alarm inactive in reset and initialize
// (R13) alarm active low power to tx turn on, inactive in ready
// (R14) alarm pin is inverse of internal alarm
// (R15) low power released in low power state leads to tx off
// (R16) transmit disable released leads to ready, alarm released
// (R17) led green in high power, amber in low power
// (R18) led blinks green and amber while overheated; code blinks only outside reset and initialize, both leds off there
// (R19) volatile registers cleared at initialization
// (R20) five bit device address field compared per frame
// (R21) frames to other port addresses ignored, line released
`timescale 1ns/1ps
module mms_top #(
    parameter int DIAG_PERIOD_CYC = mms_pkg::DIAG_PERIOD_CYC,
    parameter int BLINK_HALF_CYC = mms_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic [mms_pkg::PA_W-1:0] port_address_pins_i,
    input wire logic module_reset_pin_b_i,
    input wire logic low_power_request_i,
    input wire logic transmit_disable_request_i,
    output logic global_alarm_pin_b_o,
    output logic led_green_o,
    output logic led_amber_o,
    output logic [6:0] nvs_addr_o,
    output logic nvs_rd_o,
    input wire logic [7:0] nvs_rdata_i,
    output logic nvs_wr_o,
    output logic [7:0] nvs_wdata_o,
    input wire logic [15:0] diag_temp_i,
    input wire logic temp_high_alarm_i
);
    import mms_pkg::*;

    // ========================================
    // pin synchronisers
    logic [9:0] sy1_ff, sy2_ff;
    logic mdc_d_ff;
    logic mdc_s, bit_s, module_reset_signal, lp_s, txdis_s, rise;
    logic [PA_W-1:0] prt_s;

    // two flops on every pin, edge detect on the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sy1_ff <= SYNC_RST;
            sy2_ff <= SYNC_RST;
            mdc_d_ff <= 1'b0;
        end else begin
            sy1_ff <= {mdc_i, mdio_i, module_reset_pin_b_i,
                       low_power_request_i, transmit_disable_request_i,
                       port_address_pins_i};
            sy2_ff <= sy1_ff;
            mdc_d_ff <= sy2_ff[9];
        end
    end

    assign mdc_s = sy2_ff[9];
    assign bit_s = sy2_ff[8];
    assign module_reset_signal = ~sy2_ff[7];
    assign lp_s = sy2_ff[6];
    assign txdis_s = sy2_ff[5];
    assign prt_s = sy2_ff[4:0]; // R4
    assign rise = mdc_s & ~mdc_d_ff; // R1 R2

    // ========================================
    // module state sequence
    mms_mode_t mod_ff, nxt_mod;
    mms_agent_t ag_ff, nxt_ag;
    logic mgmt_avail, global_alarm_internal, high_pwr;

    // state walk driven by host pins
    always_comb begin
        nxt_mod = mod_ff;
        case (mod_ff)
            MS_RESET: nxt_mod = MS_INIT; // R11
            MS_INIT: if (ag_ff == AG_IDLE) nxt_mod = MS_LOPWR; // R11
            MS_LOPWR: if (!lp_s) nxt_mod = MS_HIPWRUP; // R15
            MS_HIPWRUP: nxt_mod = lp_s ? MS_LOPWR : MS_TXOFF; // R15
            MS_TXOFF: begin
                if (lp_s) nxt_mod = MS_LOPWR;
                else if (!txdis_s) nxt_mod = MS_TXON; // R16
            end
            MS_TXON: nxt_mod = txdis_s ? MS_TXOFF : MS_READY; // R16
            MS_READY: begin
                if (lp_s) nxt_mod = MS_LOPWR;
                else if (txdis_s) nxt_mod = MS_TXOFF;
            end
            default: nxt_mod = MS_RESET;
        endcase
        if (module_reset_signal) nxt_mod = MS_RESET; // R10
    end

    assign mgmt_avail = (mod_ff != MS_RESET) && (mod_ff != MS_INIT); // R10
    assign global_alarm_internal = (mod_ff == MS_LOPWR) ||
        (mod_ff == MS_HIPWRUP) || (mod_ff == MS_TXOFF) ||
        (mod_ff == MS_TXON); // R12 R13
    assign high_pwr = mgmt_avail && (mod_ff != MS_LOPWR);

    // ========================================
    // mdio frame engine
    mms_frame_t fr_ff, nxt_fr;
    logic [5:0] pre_ff, nxt_pre;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [11:0] hdr_ff, nxt_hdr;
    logic [15:0] sh_ff, nxt_sh, dout_ff, nxt_dout, addr_ff, rd_word;
    logic [15:0] fr_word, rd_a_ff, rd_b_ff;
    logic oe_ff, nxt_oe, mdo_ff, nxt_mdo, hit_ff, nxt_hit, commit;
    logic hdr_hit, is_rd, a_map, hit_nv, hit_vol, wr_a_en, save_wr;
    logic [7:0] a_idx;
    logic [7:0] stall_ff;
    logic link_stall;

    assign is_rd = hdr_ff[11];
    assign hdr_hit = (hdr_ff[9:5] == prt_s) && // R5 R21
        (hdr_ff[4:0] == MOD_DEVAD) && mgmt_avail; // R3 R20
    assign fr_word = {sh_ff[14:0], bit_s};
    assign hit_nv = addr_ff[15:7] == NVSH_BASE[15:7];
    assign hit_vol = addr_ff[15:7] == VOL_BASE[15:7];
    assign a_map = hit_nv | hit_vol;
    assign a_idx = {hit_vol, addr_ff[6:0]};
    assign rd_word = a_map ? rd_a_ff : UNMAPPED_RD;
    // a frame whose clock rests too long is cut and dropped; the host
    // clock must rise once per LINK_STALL_CYC cycles inside a frame
    assign link_stall = (stall_ff == LINK_STALL_CYC); // R6

    // bit engine, one step per management clock rise
    always_comb begin
        nxt_fr = fr_ff;
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        nxt_hdr = hdr_ff;
        nxt_sh = sh_ff;
        nxt_dout = dout_ff;
        nxt_oe = oe_ff;
        nxt_mdo = mdo_ff;
        nxt_hit = hit_ff;
        commit = 1'b0;
        if (module_reset_signal || link_stall) begin
            nxt_fr = FR_IDLE; // R6 R10
            nxt_pre = 6'h00;
            nxt_oe = 1'b0;
            nxt_mdo = 1'b0;
        end else if (rise) begin
            case (fr_ff)
                FR_IDLE: begin
                    if (bit_s) begin
                        if (pre_ff != PREAMBLE_LEN) nxt_pre = pre_ff + 6'h01;
                    end else begin
                        nxt_pre = 6'h00;
                        if (pre_ff == PREAMBLE_LEN) nxt_fr = FR_ST;
                    end
                end
                FR_ST: begin
                    nxt_fr = bit_s ? FR_IDLE : FR_HDR; // R6
                    nxt_cnt = 4'h0;
                end
                FR_HDR: begin
                    nxt_hdr = {hdr_ff[10:0], bit_s};
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        nxt_fr = FR_TA;
                        nxt_cnt = 4'h0;
                    end
                end
                FR_TA: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    nxt_sh = fr_word;
                    if (cnt_ff == 4'h0) begin
                        nxt_hit = hdr_hit;
                        nxt_dout = rd_word;
                        if (is_rd && hdr_hit) begin
                            nxt_oe = 1'b1; // turnaround zero
                            nxt_mdo = 1'b0;
                        end
                    end else begin
                        nxt_fr = FR_DATA;
                        nxt_cnt = 4'h0;
                        if (!is_rd && (fr_word[1:0] != TA_WR))
                            nxt_fr = FR_IDLE; // R6
                        if (oe_ff) begin
                            nxt_mdo = dout_ff[15];
                            nxt_dout = {dout_ff[14:0], 1'b0};
                        end
                    end
                end
                FR_DATA: begin
                    nxt_sh = fr_word;
                    nxt_cnt = cnt_ff + 4'h1;
                    nxt_mdo = dout_ff[15];
                    nxt_dout = {dout_ff[14:0], 1'b0};
                    if (cnt_ff == DATA_LAST) begin
                        nxt_fr = FR_IDLE;
                        nxt_oe = 1'b0;
                        nxt_mdo = 1'b0;
                        commit = 1'b1; // R6
                    end
                end
                default: nxt_fr = FR_IDLE;
            endcase
        end
    end

    assign wr_a_en = commit && hit_ff && (hdr_ff[11:10] == OP_WR) &&
        a_map && mgmt_avail; // R3 R6 R10
    assign save_wr = wr_a_en && (addr_ff == SAVE_REG) && fr_word[SAVE_BIT];

    // frame registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fr_ff <= FR_IDLE;
            pre_ff <= 6'h00;
            cnt_ff <= 4'h0;
            hdr_ff <= 12'h000;
            sh_ff <= 16'h0000;
            dout_ff <= 16'h0000;
            oe_ff <= 1'b0;
            mdo_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else begin
            fr_ff <= nxt_fr;
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            hdr_ff <= nxt_hdr;
            sh_ff <= nxt_sh;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            mdo_ff <= nxt_mdo;
            hit_ff <= nxt_hit;
        end
    end

    // address register: only complete address and read-increment frames move it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_ff <= ADDR_RST;
        end else if (commit && hit_ff) begin
            if (hdr_ff[11:10] == OP_ADDR) addr_ff <= fr_word; // R6
            else if (hdr_ff[11:10] == OP_RDINC) addr_ff <= addr_ff + 16'h0001;
        end
    end

    // stall timer, counts cycles since the last clock rise in a frame
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) stall_ff <= 8'h00;
        else if (rise || fr_ff == FR_IDLE) stall_ff <= 8'h00;
        else if (!link_stall) stall_ff <= stall_ff + 8'h01; // R6
    end

    assign mdio_o = mdo_ff;
    assign mdio_oe_o = oe_ff; // R10 R21

    // ========================================
    // shadow memory, host port a and agent port b
    logic [15:0] shadow [256];
    logic [6:0] idx_ff;
    logic [1:0] ph_ff;
    logic wr_b_en, diag_due, save_pend_ff, init_wr;
    logic [7:0] wr_b_idx;
    logic [15:0] wr_b_dat;
    logic [DIAG_CW-1:0] diag_cnt_ff;

    assign diag_due = mgmt_avail &&
        (diag_cnt_ff == DIAG_CW'(DIAG_PERIOD_CYC - 1)); // R9
    assign init_wr = (ag_ff == AG_LOAD) && (mod_ff == MS_INIT) &&
        (ph_ff != 2'h1);
    assign wr_b_en = diag_due || init_wr;
    assign wr_b_idx = diag_due ? {1'b1, DIAG_TEMP_IDX} :
        {(ph_ff == 2'h0), idx_ff}; // R19
    assign wr_b_dat = diag_due ? diag_temp_i :
        ((ph_ff == 2'h0) ? 16'h0000 : {8'h00, nvs_rdata_i}); // R8 R19

    // two write ports, host wins a same-entry collision
    always_ff @(posedge clk_i) begin
        if (wr_b_en) shadow[wr_b_idx] <= wr_b_dat; // R7
        if (wr_a_en) shadow[a_idx] <= save_wr ? // R7
            (fr_word & ~(16'h0001 << SAVE_BIT)) : fr_word;
        rd_a_ff <= shadow[a_idx];
        rd_b_ff <= shadow[{1'b0, idx_ff}];
    end

    // diagnostic refresh timer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) diag_cnt_ff <= '0;
        else if (!mgmt_avail || diag_due) diag_cnt_ff <= '0;
        else diag_cnt_ff <= diag_cnt_ff + DIAG_CW'(1);
    end

    // ========================================
    // nonvolatile agent: load at init, save on request
    always_comb begin
        nxt_ag = ag_ff;
        case (ag_ff)
            AG_IDLE: if (save_pend_ff) nxt_ag = AG_SAVE; // R8
            AG_LOAD, AG_SAVE: begin
                if ((ph_ff == 2'h2) && (idx_ff == NVSH_LAST)) nxt_ag = AG_IDLE;
            end
            default: nxt_ag = AG_IDLE;
        endcase
        if (mod_ff == MS_RESET) nxt_ag = AG_LOAD; // R8
    end

    // agent sequencer, three phases per byte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ag_ff <= AG_LOAD;
            idx_ff <= 7'h00;
            ph_ff <= 2'h0;
        end else begin
            ag_ff <= nxt_ag;
            if (mod_ff == MS_RESET || ag_ff == AG_IDLE) begin
                idx_ff <= 7'h00;
                ph_ff <= 2'h0;
            end else begin
                ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
                if (ph_ff == 2'h2) idx_ff <= idx_ff + 7'h01;
            end
        end
    end

    // save request latch, a new request wins over the clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) save_pend_ff <= 1'b0;
        else if (save_wr) save_pend_ff <= 1'b1;
        else if (ag_ff == AG_SAVE || mod_ff == MS_RESET) save_pend_ff <= 1'b0;
    end

    // store strobes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nvs_addr_o <= 7'h00;
            nvs_rd_o <= 1'b0;
            nvs_wr_o <= 1'b0;
            nvs_wdata_o <= 8'h00;
        end else begin
            nvs_addr_o <= idx_ff;
            nvs_rd_o <= (ag_ff == AG_LOAD) && (mod_ff == MS_INIT) &&
                (ph_ff == 2'h0); // R8
            nvs_wr_o <= (ag_ff == AG_SAVE) && (ph_ff == 2'h1); // R8
            nvs_wdata_o <= rd_b_ff[7:0];
        end
    end

    // ========================================
    // alarm pin and status led
    logic [BLINK_CW-1:0] blk_cnt_ff;
    logic blk_ff, hot;

    assign hot = mgmt_avail && temp_high_alarm_i;

    // blink time base
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            blk_cnt_ff <= '0;
            blk_ff <= 1'b0;
        end else if (blk_cnt_ff == BLINK_CW'(BLINK_HALF_CYC - 1)) begin
            blk_cnt_ff <= '0;
            blk_ff <= ~blk_ff;
        end else begin
            blk_cnt_ff <= blk_cnt_ff + BLINK_CW'(1);
        end
    end

    // state, alarm pin and led registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mod_ff <= MS_RESET;
            global_alarm_pin_b_o <= 1'b1;
            led_green_o <= 1'b0;
            led_amber_o <= 1'b0;
        end else begin
            mod_ff <= nxt_mod;
            global_alarm_pin_b_o <= ~global_alarm_internal; // R14
            led_green_o <= hot ? blk_ff : high_pwr; // R17 R18
            led_amber_o <= hot ? ~blk_ff : (mod_ff == MS_LOPWR); // R17 R18
        end
    end

    // ========================================
    // checks
    localparam int INIT_LIMIT_CYC = 400;
    logic [8:0] init_cyc_ff;
    logic [DIAG_CW:0] gap_ff;

    // helper counters for bounded checks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_cyc_ff <= 9'h000;
            gap_ff <= '0;
        end else begin
            init_cyc_ff <= (mod_ff == MS_INIT) ? init_cyc_ff + 9'h001 : 9'h000;
            gap_ff <= (!mgmt_avail || (wr_b_en && wr_b_idx[7])) ? '0 :
                gap_ff + (DIAG_CW + 1)'(1);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_rst_hiz: assert property ( // R10
        module_reset_signal |=> !mdio_oe_o)
        else $error("data line driven during reset");
    a_rst_nowr: assert property ( // R10
        (mod_ff == MS_RESET) |-> !wr_a_en)
        else $error("host write in reset");
    a_wr_devad: assert property ( // R3
        wr_a_en |-> hit_ff && (hdr_ff[4:0] == MOD_DEVAD))
        else $error("write to wrong device address");
    a_wr_whole: assert property ( // R6
        (fr_ff != FR_DATA || cnt_ff != DATA_LAST) |-> !wr_a_en)
        else $error("write from incomplete frame");
    a_stall_drop: assert property ( // R6
        link_stall |=> (fr_ff == FR_IDLE) && !mdio_oe_o)
        else $error("stalled frame not dropped");
    a_miss_hiz: assert property ( // R21
        (fr_ff == FR_DATA && !hit_ff) |-> !mdio_oe_o)
        else $error("driving for another port");
    a_init_short: assert property ( // R11
        init_cyc_ff < 9'(INIT_LIMIT_CYC))
        else $error("initialize state too long");
    a_diag_gap: assert property ( // R9
        gap_ff <= (DIAG_CW + 1)'(DIAG_PERIOD_CYC))
        else $error("diagnostic refresh late");
    a_alarm_quiet: assert property ( // R12 R13
        (mod_ff inside {MS_RESET, MS_INIT, MS_READY}) |=> global_alarm_pin_b_o)
        else $error("alarm active in quiet state");
    a_alarm_pin: assert property ( // R14
        global_alarm_internal |=> !global_alarm_pin_b_o)
        else $error("alarm pin not inverse");
    a_lp_exit: assert property ( // R15
        (mod_ff == MS_LOPWR && !lp_s && !module_reset_signal) ##1
        (!lp_s && !module_reset_signal) |=> (mod_ff == MS_TXOFF))
        else $error("low power exit missing");
    a_ready_go: assert property ( // R16
        (mod_ff == MS_TXON && !txdis_s && !module_reset_signal) |=>
        (mod_ff == MS_READY) ##1 global_alarm_pin_b_o)
        else $error("ready or alarm release missing");
    a_led_amber: assert property ( // R17
        (mod_ff == MS_LOPWR && !temp_high_alarm_i) |=>
        led_amber_o && !led_green_o)
        else $error("low power led wrong");
    a_led_blink: assert property ( // R18
        hot |=> (led_green_o != led_amber_o))
        else $error("overheat led wrong");

    c_read_drive: cover property ($rose(mdio_oe_o));
    c_ready: cover property (mod_ff == MS_READY);
    c_save: cover property (ag_ff == AG_SAVE);
    c_blink: cover property (hot && $changed(led_green_o));
endmodule : mms_top

// ### mms_pkg.sv
// package: constants and types of the module management block
package mms_pkg;
    // ========================================
    // timing
    localparam int CLK_MHZ = 125;
    localparam int MDC_MAX_KHZ = 4000;
    localparam int DIAG_PERIOD_US = 1000;
    localparam int DIAG_PERIOD_CYC = DIAG_PERIOD_US * CLK_MHZ;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam int DIAG_CW = 17;
    localparam int BLINK_CW = 26;
    // ========================================
    // frame format
    localparam int PA_W = 5;
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] MOD_DEVAD = 5'h01;
    localparam logic [1:0] OP_ADDR = 2'h0;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] OP_RDINC = 2'h2;
    localparam logic [1:0] TA_WR = 2'h2;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [3:0] DATA_LAST = 4'hF;
    // longest rest of the management clock inside a frame before a drop
    localparam logic [7:0] LINK_STALL_CYC = 8'hC8;
    // ========================================
    // register space
    localparam logic [15:0] NVSH_BASE = 16'h8000;
    localparam logic [15:0] VOL_BASE = 16'hA000;
    localparam logic [15:0] SAVE_REG = 16'hA004;
    localparam int SAVE_BIT = 5;
    localparam logic [6:0] DIAG_TEMP_IDX = 7'h60;
    localparam logic [6:0] NVSH_LAST = 7'h7F;
    localparam logic [15:0] UNMAPPED_RD = 16'h0000;
    // ========================================
    // reset values
    localparam logic [9:0] SYNC_RST = 10'h000;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    // ========================================
    // types
    typedef enum logic [2:0] {
        MS_RESET, MS_INIT, MS_LOPWR, MS_HIPWRUP, MS_TXOFF, MS_TXON, MS_READY
    } mms_mode_t;
    typedef enum logic [2:0] {
        FR_IDLE, FR_ST, FR_HDR, FR_TA, FR_DATA
    } mms_frame_t;
    typedef enum logic [1:0] {AG_IDLE, AG_LOAD, AG_SAVE} mms_agent_t;
endpackage : mms_pkg

// ### mms_host.sv
// host station manager model for the management link
`timescale 1ns/1ps
module mms_host (
    input wire logic clk_i,
    input wire logic dev_mdio_i,
    input wire logic dev_oe_i,
    output logic mdc_o,
    output logic mdio_o
);
    logic h_oe = 1'h0;
    logic h_bit = 1'h1;
    // ========================================
    // wire level: host, then device, else the pull-up
    assign mdio_o = h_oe ? h_bit : (dev_oe_i ? dev_mdio_i : 1'h1);
    initial mdc_o = 1'h0;
    // one frame, n bits long; the clock stands low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
        input logic [4:0] da, input logic [15:0] d, input int n,
        output logic [15:0] q);
        logic [63:0] v;
        v = {32'hFFFFFFFF, 2'h0, op, pa, da, 2'h2, d};
        q = 16'h0000;
        for (int i = 0; i < n; i++) begin
            h_oe <= !(op[1] && i >= 46);
            h_bit <= v[63-i];
            repeat (5) @(posedge clk_i);
            mdc_o <= 1'h1;
            if (i >= 48) q = {q[14:0], mdio_o};
            repeat (5) @(posedge clk_i);
            mdc_o <= 1'h0;
        end
        h_oe <= 1'h0;
        // rest with the clock low, long enough for a cut frame to time out
        repeat (300) @(posedge clk_i);
    endtask : frame
endmodule : mms_host

// ### tb.sv
// self-checking testbench of the module management block
`timescale 1ns/1ps
module tb;
    import mms_pkg::*;
    logic clk_i, rst_b_i, mdc, mdio, mdio_o, mdio_oe_o, rst_pin_b, lp, txd;
    logic gal_b, led_g, led_a, nvs_rd, nvs_wr, t_alarm;
    logic [4:0] pa;
    logic [6:0] nvs_addr;
    logic [7:0] nvs_rdata, nvs_wdata;
    logic [7:0] mem [128];
    logic [15:0] diag, q;
    logic [15:0] ra [5], rw [5], re [5];
    logic wen [5];
    int n_errors = 0;
    int checks = 0;
    int ng, na;
    mms_top #(.DIAG_PERIOD_CYC(200), .BLINK_HALF_CYC(20)) mms_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc), .mdio_i(mdio),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .port_address_pins_i(pa),
        .module_reset_pin_b_i(rst_pin_b), .low_power_request_i(lp),
        .transmit_disable_request_i(txd), .global_alarm_pin_b_o(gal_b),
        .led_green_o(led_g), .led_amber_o(led_a), .nvs_addr_o(nvs_addr),
        .nvs_rd_o(nvs_rd), .nvs_rdata_i(nvs_rdata), .nvs_wr_o(nvs_wr),
        .nvs_wdata_o(nvs_wdata), .diag_temp_i(diag),
        .temp_high_alarm_i(t_alarm));
    mms_host mms_host_inst (.clk_i(clk_i), .dev_mdio_i(mdio_o),
        .dev_oe_i(mdio_oe_o), .mdc_o(mdc), .mdio_o(mdio));
    // ========================================
    // clock and nonvolatile store model
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (nvs_rd) nvs_rdata <= mem[nvs_addr];
        if (nvs_wr) mem[nvs_addr] <= nvs_wdata;
    end
    // ========================================
    // compare, bus and closing tasks
    task chk16(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk16
    task chk_pin(input string s, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %b got %b", s, e, g);
        end
    endtask : chk_pin
    task rd(input logic [4:0] p, input logic [4:0] d, input logic [15:0] a);
        mms_host_inst.frame(OP_ADDR, p, d, a, 64, q);
        mms_host_inst.frame(2'h3, p, d, 16'h0000, 64, q);
    endtask : rd
    task wr(input logic [4:0] p, input logic [4:0] d, input logic [15:0] a,
        input logic [15:0] w);
        mms_host_inst.frame(OP_ADDR, p, d, a, 64, q);
        mms_host_inst.frame(OP_WR, p, d, w, 64, q);
    endtask : wr
    task finish_test;
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // watchdog against a hung sequence
    initial begin
        #700000;
        n_errors++;
        finish_test;
    end
    // ========================================
    // main sequence
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5A;
        ra = '{16'h8005, 16'hA011, 16'hA010, 16'h0100, 16'h8010};
        wen = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
        rw = '{16'h0000, 16'h0000, 16'hBEEF, 16'h1234, 16'h00C3};
        re = '{16'h005F, 16'h0000, 16'hBEEF, 16'h0000, 16'h00C3};
        rst_b_i = 1'h0;
        rst_pin_b = 1'h0;
        lp = 1'h1;
        txd = 1'h1;
        pa = 5'h0A;
        diag = 16'h1234;
        t_alarm = 1'h0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        chk_pin("alarm pin in reset", 1'h1, gal_b);
        wr(5'h0A, MOD_DEVAD, 16'hA010, 16'hDEAD);
        rd(5'h0A, MOD_DEVAD, 16'hA010);
        chk16("read in reset", 16'hFFFF, q);
        rst_pin_b <= 1'h1;
        repeat (500) @(posedge clk_i);
        chk_pin("alarm pin low power", 1'h0, gal_b);
        chk_pin("amber led", 1'h1, led_a);
        // table rows: optional write, then read back
        for (int i = 0; i < 5; i++) begin
            if (wen[i]) wr(5'h0A, MOD_DEVAD, ra[i], rw[i]);
            rd(5'h0A, MOD_DEVAD, ra[i]);
            chk16("table read", re[i], q);
        end
        // other device address: nothing driven, nothing written
        wr(5'h0A, 5'h02, 16'hA010, 16'h0000);
        rd(5'h0A, 5'h02, 16'hA010);
        chk16("other device address", 16'hFFFF, q);
        rd(5'h0B, MOD_DEVAD, 16'hA010);
        chk16("other port address", 16'hFFFF, q);
        pa <= 5'h15;
        repeat (10) @(posedge clk_i);
        // cut write frame must leave the register alone
        mms_host_inst.frame(OP_ADDR, 5'h15, MOD_DEVAD, 16'hA010, 64, q);
        mms_host_inst.frame(OP_WR, 5'h15, MOD_DEVAD, 16'h0000, 56, q);
        rd(5'h15, MOD_DEVAD, 16'hA010);
        chk16("new port address", 16'hBEEF, q);
        // read with increment, then plain read of the next word
        wr(5'h15, MOD_DEVAD, 16'hA012, 16'h5555);
        mms_host_inst.frame(OP_ADDR, 5'h15, MOD_DEVAD, 16'hA011, 64, q);
        mms_host_inst.frame(OP_RDINC, 5'h15, MOD_DEVAD, 16'h0000, 64, q);
        chk16("read increment", 16'h0000, q);
        mms_host_inst.frame(2'h3, 5'h15, MOD_DEVAD, 16'h0000, 64, q);
        chk16("next word", 16'h5555, q);
        diag <= 16'h4321;
        repeat (300) @(posedge clk_i);
        rd(5'h15, MOD_DEVAD, 16'hA060);
        chk16("diagnostic value", 16'h4321, q);
        wr(5'h15, MOD_DEVAD, SAVE_REG, 16'h0020);
        repeat (500) @(posedge clk_i);
        chk16("saved byte", 16'h00C3, {8'h00, mem[16]});
        lp <= 1'h0;
        repeat (10) @(posedge clk_i);
        chk_pin("alarm pin tx off", 1'h0, gal_b);
        chk_pin("green led", 1'h1, led_g);
        txd <= 1'h0;
        repeat (10) @(posedge clk_i);
        chk_pin("alarm pin ready", 1'h1, gal_b);
        t_alarm <= 1'h1;
        ng = 0;
        na = 0;
        repeat (100) @(posedge clk_i) begin
            ng += int'(led_g === 1'h1);
            na += int'(led_a === 1'h1);
        end
        chk_pin("led blinking", 1'h1, ng > 0 && na > 0);
        finish_test;
    end
endmodule : tb
